// file: logic/hisel_defines.vh
// Constants for the host interface strap select block.
// Assumes a 100 MHz ref_clk and that straps are steady around reset release.
//
// Contract
// - Two straps pick 8080, 6800, serial or I2C host bus.
// - Bus activity counts only while active-low chip select is low; I2C mode here ignores chip select.
// - Data/command high means display data, low means command byte.
// - In I2C the data/command pin is the slave address low bit.
// - In 6800 mode direction high is read, low is write.
// - In 8080 mode direction pin low is the write strobe.
// - In 6800 mode enable high starts the transfer.
// - In 8080 mode enable/read low is the read strobe.
// - Serial: clock on data bit 0, input bit 1, output bit 2.
// - I2C: data bits 1 and 2 form SDA, data bit 0 is SCL.
// - Line-count strap sampled at reset: high two lines, low one.
// - Common scan normal when strap is 1, reversed when 0.
// - Segment mapping ascending when strap is 1, reversed when 0.
// - Font straps pick table A, B, C; 11 leaves it to command 72h.
// - Glyph straps split ROM and RAM glyphs; 11 is 256/0, 10 is 250/6.
// - Regulator strap enables core regulator; command 71h may disable it.
// - Command 0Ch turns display on; outputs activate 100 ms later.
`ifndef HISEL_DEFINES_VH
`define HISEL_DEFINES_VH
`define HISEL_MODE_8080    2'h3
`define HISEL_MODE_6800    2'h2
`define HISEL_MODE_SERIAL  2'h0
`define HISEL_MODE_I2C     2'h1
`define HISEL_CMD_DISP_ON  8'h0C
`define HISEL_CMD_DISP_OFF 8'h08
`define HISEL_CMD_FUNC_A   8'h71
`define HISEL_CMD_FUNC_B   8'h72
`define HISEL_CMD_EXT_SET  8'h2A
`define HISEL_CMD_EXT_CLR  8'h28
`define HISEL_REG_ON_VAL   8'h5C
`define HISEL_I2C_ADDR_HI  6'h1E
`define HISEL_RST_MIN_NS   3000
`define HISEL_ON_DELAY_MS  100
`define HISEL_CLK_MHZ      100
`endif

// file: logic/hisel_fifo.v
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a clock enable that freezes all state.
`default_nettype none
module hisel_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             resetn,
  input  wire             clk_en,
  input  wire             clr,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;
  integer         i;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {WIDTH{1'b0}};
      end
    end else if (clk_en) begin
      if (clr) begin
        wr_q  <= {AW{1'b0}};
        rd_q  <= {AW{1'b0}};
        cnt_q <= {(AW+1){1'b0}};
      end else begin
        if (push) begin
          mem_q[wr_q] <= in_data;
          wr_q        <= wr_q + 1'b1;
        end
        if (pop) begin
          rd_q <= rd_q + 1'b1;
        end
        if (push && !pop) begin
          cnt_q <= cnt_q + 1'b1;
        end else if (pop && !push) begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/hisel_top.v
// Host front end: strap-chosen bus, byte decode, strap latching, display on/off.
// Assumes host pins synchronous to ref_clk; hw_reset_n is the host reset pin.
`include "hisel_defines.vh"
`default_nettype none
module hisel_top #(
  parameter        ON_DELAY_CYC = `HISEL_ON_DELAY_MS * 1000 * 1000 / 10,
  parameter        FIFO_DEPTH   = 16,
  parameter [15:0] RST_MIN_CYC  = (`HISEL_RST_MIN_NS * `HISEL_CLK_MHZ + 999) / 1000
) (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       resetn,
  input  wire       clk_en,
  // Host reset pin
  input  wire       hw_reset_n,
  // Straps
  input  wire       iface_sel_lo,
  input  wire       iface_sel_hi,
  input  wire       line_count_strap,
  input  wire       common_dir_strap,
  input  wire       segment_dir_strap,
  input  wire [1:0] font_table_straps,
  input  wire [1:0] glyph_split_straps,
  input  wire       core_regulator_strap,
  // Host bus pins
  input  wire       chip_sel_n,
  input  wire       data_cmd_sel,
  input  wire       dir_pin,
  input  wire       enable_pin,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg  [7:0] data_oe,
  // Core side byte stream and read data
  output wire       rx_valid,
  input  wire       rx_ready,
  output wire       rx_is_data,
  output wire [7:0] rx_byte,
  input  wire [7:0] rd_data,
  output reg        rd_strobe,
  // Configuration state
  output reg  [1:0] bus_mode_q,
  output reg        two_line_q,
  output reg        com_normal_q,
  output reg        seg_normal_q,
  output reg  [1:0] font_table_q,
  output reg  [8:0] rom_glyphs_q,
  output reg  [3:0] ram_glyphs_q,
  output reg        regulator_on_q,
  output reg        ext_set_flag_q,
  output reg        display_on_q,
  output reg        outputs_active_q,
  output reg        regs_reset_q,
  output wire [6:0] i2c_addr
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_SKIP = 2'h3;
  localparam [31:0] ON_CNT = ON_DELAY_CYC;

  reg        hw_rst_prev_q;
  reg [15:0] rst_cnt_q;
  reg        sample_q;
  reg        dir_prev_q;
  reg        en_prev_q;
  reg        sclk_prev_q;
  reg        sda_prev_q;
  reg [7:0]  sh_q;
  reg [3:0]  bit_q;
  reg [1:0]  i2c_st_q;
  reg        ack_q;
  reg        arg_q;
  reg [7:0]  arg_cmd_q;
  reg [31:0] on_cnt_q;
  reg        wr_ok;
  reg [7:0]  wr_byte;
  reg        wr_dc;
  wire       sel;
  wire       sclk;
  wire       sda;
  wire       in_ready;
  wire       fifo_valid;
  wire [8:0] fifo_word;
  wire       consume;

  assign sel  = ~chip_sel_n;
  assign sclk = data_in[0];
  assign sda  = data_in[1];
  assign i2c_addr = {`HISEL_I2C_ADDR_HI, data_cmd_sel};

  // Glyph split decode; 00 and 01 follow the same table for completeness.
  function [12:0] glyph_split;
    input [1:0] code;
    begin
      case (code)
        2'h3:    glyph_split = {9'h100, 4'h0};
        2'h2:    glyph_split = {9'h0FA, 4'h6};
        2'h1:    glyph_split = {9'h0F8, 4'h8};
        default: glyph_split = {9'h0F0, 4'h8};
      endcase
    end
  endfunction

  // Byte capture per bus mode; strobes only count with chip select low, except in I2C, which ignores it.
  always @* begin
    wr_ok   = 1'b0;
    wr_byte = data_in;
    wr_dc   = data_cmd_sel;
    case (bus_mode_q)
      `HISEL_MODE_8080: wr_ok = sel && dir_prev_q && !dir_pin;
      `HISEL_MODE_6800: wr_ok = sel && !en_prev_q && enable_pin && !dir_pin;
      `HISEL_MODE_SERIAL: begin
        wr_ok   = sel && !sclk_prev_q && sclk && (bit_q == 4'h7);
        wr_byte = {sh_q[6:0], sda};
      end
      `HISEL_MODE_I2C: begin
        wr_ok   = !sclk_prev_q && sclk && (bit_q == 4'h7) && (i2c_st_q == ST_DATA);
        wr_byte = {sh_q[6:0], sda};
        wr_dc   = 1'b0;
      end
      default: wr_ok = 1'b0;
    endcase
  end

  hisel_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .clr       (regs_reset_q),
    .in_valid  (wr_ok),
    .in_ready  (in_ready),
    .in_data   ({wr_dc, wr_byte}),
    .out_valid (fifo_valid),
    .out_ready (rx_ready),
    .out_data  (fifo_word)
  );

  assign rx_valid   = fifo_valid;
  assign rx_is_data = fifo_word[8];
  assign rx_byte    = fifo_word[7:0];
  assign consume    = fifo_valid & rx_ready;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hw_rst_prev_q    <= 1'b1;
      rst_cnt_q        <= 16'h0000;
      sample_q         <= 1'b1;
      regs_reset_q     <= 1'b0;
      bus_mode_q       <= `HISEL_MODE_8080;
      two_line_q       <= 1'b1;
      com_normal_q     <= 1'b1;
      seg_normal_q     <= 1'b1;
      font_table_q     <= 2'h0;
      rom_glyphs_q     <= 9'h100;
      ram_glyphs_q     <= 4'h0;
      regulator_on_q   <= 1'b1;
      ext_set_flag_q   <= 1'b0;
      display_on_q     <= 1'b0;
      outputs_active_q <= 1'b0;
      on_cnt_q         <= 32'h0000_0000;
      dir_prev_q       <= 1'b1;
      en_prev_q        <= 1'b0;
      sclk_prev_q      <= 1'b0;
      sda_prev_q       <= 1'b1;
      sh_q             <= 8'h00;
      bit_q            <= 4'h0;
      i2c_st_q         <= ST_IDLE;
      ack_q            <= 1'b0;
      arg_q            <= 1'b0;
      arg_cmd_q        <= 8'h00;
      data_out         <= 8'h00;
      data_oe          <= 8'h00;
      rd_strobe        <= 1'b0;
    end else if (clk_en) begin
      hw_rst_prev_q <= hw_reset_n;
      dir_prev_q    <= dir_pin;
      en_prev_q     <= enable_pin;
      sclk_prev_q   <= sclk;
      sda_prev_q    <= sda;
      rd_strobe     <= 1'b0;
      regs_reset_q  <= 1'b0;
      // Count the reset pulse; too short a pulse is treated as a glitch.
      if (!hw_reset_n) begin
        if (rst_cnt_q != 16'hFFFF) begin
          rst_cnt_q <= rst_cnt_q + 16'h0001;
        end
      end else begin
        rst_cnt_q <= 16'h0000;
      end
      // Straps are caught one cycle after reset release, never under reset.
      if (sample_q) begin
        sample_q         <= 1'b0;
        bus_mode_q       <= {iface_sel_hi, iface_sel_lo};
        two_line_q       <= line_count_strap;
        com_normal_q     <= common_dir_strap;
        seg_normal_q     <= segment_dir_strap;
        font_table_q     <= (font_table_straps == 2'h3) ? 2'h0 : font_table_straps;
        {rom_glyphs_q, ram_glyphs_q} <= glyph_split(glyph_split_straps);
        regulator_on_q   <= core_regulator_strap;
        ext_set_flag_q   <= 1'b0;
        display_on_q     <= 1'b0;
        outputs_active_q <= 1'b0;
        arg_q            <= 1'b0;
        bit_q            <= 4'h0;
        i2c_st_q         <= ST_IDLE;
      end
      // A valid host reset re-arms strap sampling after the clear above, so the set wins.
      if (hw_reset_n && !hw_rst_prev_q && rst_cnt_q >= RST_MIN_CYC) begin
        regs_reset_q <= 1'b1;
        sample_q     <= 1'b1;
      end
      // Read path: parallel modes drive the bus while the read strobe is on.
      case (bus_mode_q)
        `HISEL_MODE_8080: begin
          data_oe   <= (sel && !enable_pin) ? 8'hFF : 8'h00;
          data_out  <= rd_data;
          rd_strobe <= sel && en_prev_q && !enable_pin;
        end
        `HISEL_MODE_6800: begin
          data_oe   <= (sel && enable_pin && dir_pin) ? 8'hFF : 8'h00;
          data_out  <= rd_data;
          rd_strobe <= sel && !en_prev_q && enable_pin && dir_pin;
        end
        `HISEL_MODE_SERIAL: begin
          data_oe  <= sel ? 8'h04 : 8'h00;
          data_out <= {5'h00, sh_q[7], 2'h0};
        end
        default: begin
          data_oe  <= ack_q ? 8'h04 : 8'h00;
          data_out <= 8'h00;
        end
      endcase
      // Serial and I2C bit shifter.
      if (bus_mode_q == `HISEL_MODE_SERIAL) begin
        if (!sel) begin
          bit_q <= 4'h0;
        end else if (!sclk_prev_q && sclk) begin
          sh_q  <= {sh_q[6:0], sda};
          bit_q <= (bit_q == 4'h7) ? 4'h0 : bit_q + 4'h1;
        end
      end else if (bus_mode_q == `HISEL_MODE_I2C) begin
        if (sclk && sda_prev_q && !sda) begin
          i2c_st_q <= ST_ADDR;
          bit_q    <= 4'h0;
          ack_q    <= 1'b0;
        end else if (sclk && !sda_prev_q && sda) begin
          i2c_st_q <= ST_IDLE;
          ack_q    <= 1'b0;
        end else if (!sclk_prev_q && sclk && i2c_st_q != ST_IDLE) begin
          sh_q  <= {sh_q[6:0], sda};
          bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
          if (bit_q == 4'h7 && i2c_st_q == ST_ADDR) begin
            i2c_st_q <= ({sh_q[6:0], sda} == {i2c_addr, 1'b0}) ? ST_DATA : ST_SKIP;
          end
        end else if (sclk_prev_q && !sclk) begin
          ack_q <= (bit_q == 4'h8) && (i2c_st_q != ST_SKIP);
        end
      end
      // Command decode on bytes leaving the FIFO.
      if (consume && !rx_is_data) begin
        arg_q <= 1'b0;
        if (rx_byte == `HISEL_CMD_EXT_SET) begin
          ext_set_flag_q <= 1'b1;
        end else if (rx_byte == `HISEL_CMD_EXT_CLR) begin
          ext_set_flag_q <= 1'b0;
        end else if (!ext_set_flag_q && rx_byte == `HISEL_CMD_DISP_ON) begin
          display_on_q <= 1'b1;
          on_cnt_q     <= 32'h0000_0000;
        end else if (!ext_set_flag_q && rx_byte == `HISEL_CMD_DISP_OFF) begin
          display_on_q     <= 1'b0;
          outputs_active_q <= 1'b0;
        end else if (ext_set_flag_q && (rx_byte == `HISEL_CMD_FUNC_A ||
                     rx_byte == `HISEL_CMD_FUNC_B)) begin
          arg_q     <= 1'b1;
          arg_cmd_q <= rx_byte;
        end
      end else if (consume && arg_q) begin
        arg_q <= 1'b0;
        if (arg_cmd_q == `HISEL_CMD_FUNC_A) begin
          regulator_on_q <= (rx_byte == `HISEL_REG_ON_VAL) && core_regulator_strap;
        end else begin
          if (font_table_straps == 2'h3 && rx_byte[3:2] != 2'h3) begin
            font_table_q <= rx_byte[3:2];
          end
          {rom_glyphs_q, ram_glyphs_q} <= glyph_split(rx_byte[1:0]);
        end
      end
      // Outputs come up a fixed delay after the display-on command.
      if (display_on_q && !outputs_active_q) begin
        if (on_cnt_q >= ON_CNT - 32'h1) begin
          outputs_active_q <= 1'b1;
        end else begin
          on_cnt_q <= on_cnt_q + 32'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/hisel_top_asserts.sv
// Checker for the host front end, bound to the top module and watching its ports only.
// Assumes clk_en stays high, so every clock edge is a working edge.
`include "hisel_defines.vh"
`default_nettype none
module hisel_chk #(
  parameter int          ON_DELAY_CYC = 20,
  parameter logic [15:0] RST_MIN_CYC  = 16'h0004
) (
  // Clock and resets
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       hw_reset_n,
  // Straps
  input wire logic [1:0] font_table_straps,
  input wire logic [1:0] glyph_split_straps,
  // Host bus
  input wire logic       chip_sel_n,
  input wire logic       data_cmd_sel,
  input wire logic       dir_pin,
  input wire logic       enable_pin,
  input wire logic [7:0] data_in,
  // Core side
  input wire logic       rx_valid,
  input wire logic       rx_is_data,
  input wire logic [7:0] rx_byte,
  input wire logic       rd_strobe,
  // State
  input wire logic [1:0] bus_mode_q,
  input wire logic [1:0] font_table_q,
  input wire logic [8:0] rom_glyphs_q,
  input wire logic [3:0] ram_glyphs_q,
  input wire logic       display_on_q,
  input wire logic       outputs_active_q,
  input wire logic       regs_reset_q,
  input wire logic [6:0] i2c_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [31:0] on_cnt_q;
  logic [15:0] lo_cnt_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      on_cnt_q <= 32'h0000_0000;
      lo_cnt_q <= 16'h0000;
    end else begin
      on_cnt_q <= (display_on_q && !outputs_active_q) ? on_cnt_q + 32'h0000_0001 : 32'h0000_0000;
      lo_cnt_q <= hw_reset_n ? 16'h0000 : lo_cnt_q + {15'h0000, ~&lo_cnt_q};
    end
  end
  property p_addr; i2c_addr == {`HISEL_I2C_ADDR_HI, data_cmd_sel}; endproperty
  a_addr: assert property (p_addr) else $error("slave address wrong");
  property p_wr80;
    bus_mode_q == `HISEL_MODE_8080 && !chip_sel_n && $fell(dir_pin) && !rx_valid
      |=> rx_valid && rx_byte == $past(data_in) && rx_is_data == $past(data_cmd_sel);
  endproperty
  a_wr80: assert property (p_wr80) else $error("write strobe byte lost");
  property p_wr68;
    bus_mode_q == `HISEL_MODE_6800 && !chip_sel_n && $rose(enable_pin) && !dir_pin && !rx_valid
      |=> rx_valid && rx_byte == $past(data_in) && !rd_strobe;
  endproperty
  a_wr68: assert property (p_wr68) else $error("enable write byte lost");
  property p_rd;
    !chip_sel_n && ((bus_mode_q == `HISEL_MODE_8080 && $fell(enable_pin))
      || (bus_mode_q == `HISEL_MODE_6800 && $rose(enable_pin) && dir_pin))
      |=> rd_strobe ##1 !rd_strobe;
  endproperty
  a_rd: assert property (p_rd) else $error("read start missed");
  property p_cs;
    bus_mode_q[1] && chip_sel_n && $past(chip_sel_n) && !rx_valid |=> !rx_valid;
  endproperty
  a_cs: assert property (p_cs) else $error("byte taken while deselected");
  property p_glyph;
    regs_reset_q |-> ##2 font_table_q == (&font_table_straps ? 2'h0 : font_table_straps)
      && {rom_glyphs_q, ram_glyphs_q} == (glyph_split_straps == 2'h3 ? 13'h1000 :
      glyph_split_straps == 2'h2 ? 13'h0fa6 : glyph_split_straps == 2'h1 ? 13'h0f88 : 13'h0f08);
  endproperty
  a_glyph: assert property (p_glyph) else $error("font or glyph split wrong");
  property p_on; $rose(outputs_active_q) |-> on_cnt_q == ON_DELAY_CYC; endproperty
  a_on: assert property (p_on) else $error("display on delay wrong");
  property p_rst;
    $rose(hw_reset_n) |=> regs_reset_q == ($past(lo_cnt_q) >= RST_MIN_CYC);
  endproperty
  a_rst: assert property (p_rst) else $error("host reset pulse misjudged");
endmodule
bind hisel_top hisel_chk #(.ON_DELAY_CYC(ON_DELAY_CYC), .RST_MIN_CYC(RST_MIN_CYC)) chk_u (
  .ref_clk, .resetn, .hw_reset_n, .font_table_straps, .glyph_split_straps, .chip_sel_n,
  .data_cmd_sel, .dir_pin, .enable_pin, .data_in, .rx_valid, .rx_is_data, .rx_byte, .rd_strobe,
  .bus_mode_q, .font_table_q, .rom_glyphs_q, .ram_glyphs_q, .display_on_q, .outputs_active_q,
  .regs_reset_q, .i2c_addr);
`default_nettype wire

// file: sim/hisel_host.sv
// Host model: 8080 or 6800 style parallel master, serial master and I2C master on shared pins.
// Assumes one bench process calls its tasks, all aligned to ref_clk.
`default_nettype none
module hisel_host (
  // Clock
  input  wire logic       ref_clk,
  // Device half of the data pins
  input  wire logic [7:0] data_out,
  input  wire logic [7:0] data_oe,
  // Host pins
  output var  logic       chip_sel_n,
  output var  logic       data_cmd_sel,
  output var  logic       dir_pin,
  output var  logic       enable_pin,
  output wire logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       m68 = 1'b0;
  logic       hoe = 1'b1;
  logic [7:0] hv  = 8'h00;
  // A released line shows the inverse of the last host byte, so stale data never passes.
  assign data_in = (data_oe & data_out) | (~data_oe & (hoe ? hv : ~hv));
  initial begin
    chip_sel_n = 1'b1;
    data_cmd_sel = 1'b1;
    dir_pin = 1'b1;
    enable_pin = 1'b1;
  end
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic idle(input logic six);
    m68 = six;
    chip_sel_n = 1'b1;
    dir_pin = ~six;
    enable_pin = ~six;
  endtask
  task automatic wr(input logic csn, input logic dc, input logic [7:0] b);
    tick;
    chip_sel_n = csn;
    data_cmd_sel = dc;
    hv = b;
    hoe = 1'b1;
    tick;
    dir_pin = 1'b0;
    enable_pin = 1'b1;
    tick;
    idle(m68);
  endtask
  task automatic rd(output logic [7:0] q);
    tick;
    chip_sel_n = 1'b0;
    hoe = 1'b0;
    dir_pin = 1'b1;
    tick;
    enable_pin = m68;
    repeat (3) tick;
    q = data_in;
    idle(m68);
    hoe = 1'b1;
  endtask
  task automatic ser(input logic dc, input logic [7:0] b, output logic [7:0] oe);
    int i;
    tick;
    chip_sel_n = 1'b0;
    data_cmd_sel = dc;
    for (i = 7; i >= 0; i--) begin
      hv = {6'h00, b[i], 1'b0};
      tick;
      hv[0] = 1'b1;
      tick;
    end
    oe = data_oe;
    hv = 8'h00;
    tick;
    chip_sel_n = 1'b1;
  endtask
  task automatic i2c_start;
    chip_sel_n = 1'b0;
    dir_pin = 1'b0;
    enable_pin = 1'b0;
    hv = 8'h03;
    tick;
    hv = 8'h01;
    tick;
  endtask
  task automatic i2c_stop;
    hv = 8'h00;
    tick;
    hv = 8'h01;
    tick;
    hv = 8'h03;
    tick;
  endtask
  // The ninth bit leaves the data line high; the acknowledge shows as the device's enable.
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    logic [8:0] w;
    int         i;
    w = {b, 1'b1};
    for (i = 8; i >= 0; i--) begin
      hv = {6'h00, w[i], 1'b0};
      tick;
      hv[0] = 1'b1;
      tick;
    end
    ack = data_oe[2];
  endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Bench for the host front end: straps, parallel, serial and I2C writes, reads, FIFO, display.
// Assumes the design sources and the host model are compiled ahead of this file.
`include "hisel_defines.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ON_CYC = 20;
  localparam int RST_CYC = 4;
  logic       ref_clk;
  logic       resetn;
  logic       hw_reset_n;
  logic       rx_ready;
  logic [7:0] rd_data;
  logic [9:0] st;
  wire        chip_sel_n;
  wire        data_cmd_sel;
  wire        dir_pin;
  wire        enable_pin;
  wire  [7:0] data_in;
  wire  [7:0] data_out;
  wire  [7:0] data_oe;
  int         mismatches = 0;
  int         n_compared = 0;
  hisel_top #(.ON_DELAY_CYC(ON_CYC), .FIFO_DEPTH(16), .RST_MIN_CYC(16'(RST_CYC))) dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1), .hw_reset_n(hw_reset_n),
    .iface_sel_lo(st[0]), .iface_sel_hi(st[1]), .line_count_strap(st[2]),
    .common_dir_strap(st[3]), .segment_dir_strap(st[4]), .font_table_straps(st[6:5]),
    .glyph_split_straps(st[8:7]), .core_regulator_strap(st[9]), .chip_sel_n(chip_sel_n),
    .data_cmd_sel(data_cmd_sel), .dir_pin(dir_pin), .enable_pin(enable_pin),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .rx_valid(), .rx_ready(rx_ready),
    .rx_is_data(), .rx_byte(), .rd_data(rd_data), .rd_strobe(), .bus_mode_q(), .two_line_q(),
    .com_normal_q(), .seg_normal_q(), .font_table_q(), .rom_glyphs_q(), .ram_glyphs_q(),
    .regulator_on_q(), .ext_set_flag_q(), .display_on_q(), .outputs_active_q(),
    .regs_reset_q(), .i2c_addr());
  hisel_host host_u (.ref_clk(ref_clk), .data_out(data_out), .data_oe(data_oe),
    .chip_sel_n(chip_sel_n), .data_cmd_sel(data_cmd_sel), .dir_pin(dir_pin),
    .enable_pin(enable_pin), .data_in(data_in));
  wire [20:0] cfg = {dut_u.bus_mode_q, dut_u.two_line_q, dut_u.com_normal_q, dut_u.seg_normal_q,
    dut_u.font_table_q, dut_u.rom_glyphs_q, dut_u.ram_glyphs_q, dut_u.regulator_on_q};
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask
  task automatic pop(input logic dc, input logic [7:0] b);
    int i;
    for (i = 0; i < 8 && dut_u.rx_valid !== 1'b1; i++)
      host_u.tick;
    chk("rx_word", {dc, b}, {dut_u.rx_is_data, dut_u.rx_byte});
    rx_ready = 1'b1;
    host_u.tick;
    rx_ready = 1'b0;
  endtask
  task automatic send(input logic dc, input logic [7:0] b);
    host_u.wr(1'b0, dc, b);
    pop(dc, b);
  endtask
  task automatic t_fifo;
    int i;
    host_u.wr(1'b1, 1'b0, 8'hee);
    // The seventeenth byte finds the FIFO full and must vanish.
    for (i = 0; i < 17; i++)
      host_u.wr(1'b0, i[0], 8'h10 + 8'(i));
    for (i = 0; i < 16; i++)
      pop(i[0], 8'h10 + 8'(i));
    host_u.tick;
    chk("rx_valid", 32'h0000_0000, dut_u.rx_valid);
    $display("test fifo done");
  endtask
  task automatic t_read(input logic [7:0] v);
    logic [7:0] q;
    rd_data = v;
    host_u.rd(q);
    chk("read", v, q);
    $display("test read done");
  endtask
  task automatic t_disp;
    send(1'b0, `HISEL_CMD_EXT_SET);
    send(1'b0, `HISEL_CMD_FUNC_A);
    send(1'b1, 8'h00);
    send(1'b0, `HISEL_CMD_EXT_CLR);
    send(1'b0, `HISEL_CMD_DISP_ON);
    host_u.tick;
    chk("on", 3'h1, {dut_u.regulator_on_q, dut_u.ext_set_flag_q, dut_u.display_on_q});
    repeat (ON_CYC / 2) host_u.tick;
    chk("early", 1'h0, dut_u.outputs_active_q);
    repeat (ON_CYC) host_u.tick;
    chk("active", 1'h1, dut_u.outputs_active_q);
    send(1'b0, `HISEL_CMD_DISP_OFF);
    host_u.tick;
    chk("off", 2'h0, {dut_u.display_on_q, dut_u.outputs_active_q});
    $display("test display done");
  endtask
  task automatic t_hwrst;
    int i;
    st = 10'h06e;
    host_u.idle(1'b1);
    hw_reset_n = 1'b0;
    repeat (RST_CYC / 2) host_u.tick;
    hw_reset_n = 1'b1;
    repeat (4) host_u.tick;
    chk("mode_kept", 2'h3, dut_u.bus_mode_q);
    hw_reset_n = 1'b0;
    repeat (RST_CYC * 2) host_u.tick;
    hw_reset_n = 1'b1;
    for (i = 0; i < 8 && dut_u.regs_reset_q !== 1'b1; i++)
      host_u.tick;
    chk("regs_reset", 1'h1, dut_u.regs_reset_q);
    repeat (3) host_u.tick;
    chk("cfg2", {2'h2, 3'h6, 2'h0, 9'h0f0, 4'h8, 1'h0}, cfg);
    send(1'b1, 8'h3c);
    $display("test host reset done");
  endtask
  task automatic hw_rst(input logic [9:0] s);
    st = s;
    hw_reset_n = 1'b0;
    repeat (RST_CYC * 2) host_u.tick;
    hw_reset_n = 1'b1;
    repeat (4) host_u.tick;
  endtask
  task automatic t_straps;
    chk("cfg1", {2'h3, 3'h1, 2'h1, 9'h0fa, 4'h6, 1'h1}, cfg);
    chk("i2c_addr", {6'h1e, 1'h1}, dut_u.i2c_addr);
    $display("test straps done");
  endtask
  task automatic t_soft;
    send(1'b0, `HISEL_CMD_EXT_SET);
    send(1'b0, `HISEL_CMD_FUNC_B);
    send(1'b1, 8'h09);
    host_u.tick;
    chk("soft", {2'h2, 9'h0f8, 4'h8},
        {dut_u.font_table_q, dut_u.rom_glyphs_q, dut_u.ram_glyphs_q});
    send(1'b0, `HISEL_CMD_EXT_CLR);
    $display("test soft font done");
  endtask
  task automatic t_serial;
    logic [7:0] oe;
    host_u.idle(1'b1);
    hw_rst(10'h000);
    chk("cfg_ser", {2'h0, 3'h0, 2'h0, 9'h0f0, 4'h8, 1'h0}, cfg);
    host_u.ser(1'b1, 8'hc3, oe);
    chk("sod_oe", 8'h04, oe);
    pop(1'b1, 8'hc3);
    $display("test serial done");
  endtask
  task automatic t_i2c;
    logic a;
    hw_rst(10'h001);
    chk("mode_i2c", 2'h1, dut_u.bus_mode_q);
    host_u.i2c_start;
    host_u.i2c_byte({`HISEL_I2C_ADDR_HI, ~data_cmd_sel, 1'b0}, a);
    chk("nack", 1'h0, a);
    host_u.i2c_stop;
    host_u.i2c_start;
    host_u.i2c_byte({`HISEL_I2C_ADDR_HI, data_cmd_sel, 1'b0}, a);
    chk("ack", 1'h1, a);
    host_u.i2c_byte(8'h5a, a);
    host_u.i2c_stop;
    pop(1'b0, 8'h5a);
    $display("test i2c done");
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    // The tests need about three hundred cycles; twenty thousand means a hang.
    #200000;
    mismatches++;
    end_of_test;
  end
  initial begin
    rd_data = 8'h00;
    rx_ready = 1'b0;
    hw_reset_n = 1'b1;
    st = 10'h333;
    resetn = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    repeat (2) host_u.tick;
    t_straps;
    t_fifo;
    t_read(8'ha5);
    t_disp;
    t_hwrst;
    t_read(8'h96);
    t_soft;
    t_serial;
    t_i2c;
    end_of_test;
  end
endmodule
`default_nettype wire
